// ### rtl/scs_defines.svh
// Purpose: constants of the system clock selection block
// Assumes: one clock, synchronous reset, plain register port
// Notes: types live in scs_pkg
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SCS_ADDR_W 2
`define SCS_ADDR_MODE 2'h0
`define SCS_ADDR_STAT 2'h1
`define SCS_ADDR_MCYC 2'h2

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCS_SRC_LSB 0
`define SCS_DIV_LSB 2
`define SCS_STAT_RSVD_BIT 2
`define SCS_MODE_RESET 4'hC
`define SCS_SRC_RESERVED 2'h3

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SCS_RING_DIV 8
`define SCS_STEP_LAST 2'h2

`endif

// ### rtl/scs_pkg.sv
// Purpose: shared types of the system clock selection block
// Assumes: nothing beyond the defines header
// Notes: enum order matches the mode register codes
package scs_pkg;

    typedef enum logic [1:0] {
        SCS_SRC_RING,
        SCS_SRC_MAIN,
        SCS_SRC_SUB,
        SCS_SRC_RSVD
    } scs_src_t;

    typedef enum logic [1:0] {
        SCS_DIV_1,
        SCS_DIV_2,
        SCS_DIV_4,
        SCS_DIV_8
    } scs_div_t;

    typedef struct packed {
        scs_div_t divide;
        scs_src_t source;
    } scs_mode_t;

endpackage

// ### rtl/scs_prescale.sv
// Purpose: power-of-two divider of a source tick stream
// Assumes: tick_in is a one-cycle pulse
// Notes: restart clears the count so a new ratio starts clean
`timescale 1ns/1ps
module scs_prescale (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic tick_in,
    input wire logic [1:0] sel,
    output logic tick_out
);
    logic [2:0] cnt_q;
    logic [3:0] mask;

    assign mask = (4'h1 << sel) - 4'h1;

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cnt_q <= 3'h0;
        end else if (tick_in) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && ((cnt_q & mask[2:0]) == mask[2:0]);
        end
    end
endmodule

// ### rtl/scs_div3.sv
// Purpose: divide-by-three of the system clock ticks
// Assumes: tick_in is a one-cycle pulse
// Notes: phase shows where the machine cycle stands
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_div3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic tick_in,
    output logic tick_out,
    output logic [1:0] phase
);
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            phase <= 2'h0;
        end else if (tick_in) begin
            phase <= (phase == `SCS_STEP_LAST) ? 2'h0 : phase + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (phase == `SCS_STEP_LAST);
        end
    end
endmodule

// ### rtl/scs_clock_select.sv
// Purpose: system clock source and ratio selection, instruction clock
// Assumes: pin inputs synchronous to CLK, sources slower than CLK/2
// Notes: clocks are carried as one-cycle tick pulses, not real clocks
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_clock_select #(
    parameter int RING_DIV = `SCS_RING_DIV
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // oscillator inputs
    input wire logic MAIN_OSC_IN,
    input wire logic SUB_OSC_IN,
    // register port
    input wire logic [`SCS_ADDR_W-1:0] ADDR,
    input wire logic [3:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [3:0] RDATA,
    // mode and derived clocks
    output scs_pkg::scs_mode_t MODE,
    output logic CORE_TIMEBASE,
    output logic CPU_STEP_CLOCK,
    output logic [1:0] CPU_STEP_PHASE,
    output logic MACHINE_CYCLE
);
    import scs_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    scs_mode_t mode_q;
    logic rsvd_hit_q;
    logic restart_q;
    logic [3:0] mcyc_q;
    logic [3:0] rdata_q;
    logic main_prev_q;
    logic sub_prev_q;
    logic [7:0] ring_cnt_q;
    logic ring_tick_q;
    logic main_tick_q;
    logic sub_tick_q;
    logic src_tick_q;
    logic src_tick_d;
    logic core_tick;
    logic step_tick;
    logic [1:0] step_phase;
    logic wr_mode;
    logic wr_stat;
    logic rsvd_wr;
    scs_mode_t mode_d;

    assign wr_mode = WR && (ADDR == `SCS_ADDR_MODE);
    assign wr_stat = WR && (ADDR == `SCS_ADDR_STAT);
    assign rsvd_wr = wr_mode && (WDATA[1:0] == `SCS_SRC_RESERVED);

    // ----------------------------------------
    // mode register
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        mode_d.divide = scs_div_t'(WDATA[`SCS_DIV_LSB+1:`SCS_DIV_LSB]);
        if (!rsvd_wr) begin
            mode_d.source = scs_src_t'(WDATA[`SCS_SRC_LSB+1:`SCS_SRC_LSB]);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_q <= `SCS_MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= mode_d;
        end
    end

    // restarting the dividers on a change avoids a runt first tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_mode && (mode_d != mode_q);
        end
    end

    // reserved write flagged, set beats clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            rsvd_hit_q <= 1'b0;
        end else if (rsvd_wr) begin
            rsvd_hit_q <= 1'b1;
        end else if (wr_stat && WDATA[`SCS_STAT_RSVD_BIT]) begin
            rsvd_hit_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST || !RD) begin
            rdata_q <= 4'h0;
        end else begin
            unique case (ADDR)
                `SCS_ADDR_MODE: rdata_q <= mode_q;
                `SCS_ADDR_STAT: rdata_q <= {1'b0, rsvd_hit_q, mode_q.source};
                `SCS_ADDR_MCYC: rdata_q <= mcyc_q;
                default: rdata_q <= 4'h0;
            endcase
        end
    end

    // ----------------------------------------
    // source clocks
    // ----------------------------------------
    // on-chip oscillator from CLK
    always_ff @(posedge CLK) begin
        if (RST) begin
            ring_cnt_q <= 8'h00;
            ring_tick_q <= 1'b0;
        end else if (ring_cnt_q == 8'(RING_DIV - 1)) begin
            ring_cnt_q <= 8'h00;
            ring_tick_q <= 1'b1;
        end else begin
            ring_cnt_q <= ring_cnt_q + 8'h01;
            ring_tick_q <= 1'b0;
        end
    end

    // main pin serves all three kinds
    always_ff @(posedge CLK) begin
        if (RST) begin
            main_prev_q <= 1'b0;
            main_tick_q <= 1'b0;
        end else begin
            main_prev_q <= MAIN_OSC_IN;
            main_tick_q <= MAIN_OSC_IN && !main_prev_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sub_prev_q <= 1'b0;
            sub_tick_q <= 1'b0;
        end else begin
            sub_prev_q <= SUB_OSC_IN;
            sub_tick_q <= SUB_OSC_IN && !sub_prev_q;
        end
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    always_comb begin
        unique case (mode_q.source)
            SCS_SRC_RING: src_tick_d = ring_tick_q;
            SCS_SRC_MAIN: src_tick_d = main_tick_q;
            SCS_SRC_SUB: src_tick_d = sub_tick_q;
            SCS_SRC_RSVD: src_tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            src_tick_q <= 1'b0;
        end else begin
            src_tick_q <= src_tick_d;
        end
    end

    // ----------------------------------------
    // dividers
    // ----------------------------------------
    scs_prescale u_prescale (
        .clk(CLK),
        .rst(RST),
        .restart(restart_q),
        .tick_in(src_tick_q),
        .sel(mode_q.divide),
        .tick_out(core_tick)
    );

    scs_div3 u_div3 (
        .clk(CLK),
        .rst(RST),
        .restart(restart_q),
        .tick_in(core_tick),
        .tick_out(step_tick),
        .phase(step_phase)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            mcyc_q <= 4'h0;
        end else if (step_tick) begin
            mcyc_q <= mcyc_q + 4'h1;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign RDATA = rdata_q;
    assign MODE = mode_q;
    assign CORE_TIMEBASE = core_tick;
    assign CPU_STEP_CLOCK = step_tick;
    assign CPU_STEP_PHASE = step_phase;
    assign MACHINE_CYCLE = step_tick;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [2:0] core_seen_q;

    always_ff @(posedge CLK) begin
        if (RST || restart_q) begin
            core_seen_q <= 3'h0;
        end else if (step_tick) begin
            core_seen_q <= core_tick ? 3'h1 : 3'h0;
        end else if (core_tick && core_seen_q != 3'h7) begin
            core_seen_q <= core_seen_q + 3'h1;
        end
    end

    property p_reset_mode;
        @(posedge CLK) RST |=> (mode_q == `SCS_MODE_RESET) && !CORE_TIMEBASE;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not reset");

    property p_src_write;
        @(posedge CLK) disable iff (RST)
        (wr_mode && !rsvd_wr) |=> (mode_q.source == $past(WDATA[1:0]));
    endproperty
    a_src_write: assert property (p_src_write) else $error("source not taken");

    property p_div_write;
        @(posedge CLK) disable iff (RST)
        wr_mode |=> (mode_q.divide == $past(WDATA[3:2]));
    endproperty
    a_div_write: assert property (p_div_write) else $error("divide not taken");

    property p_rsvd_keep;
        @(posedge CLK) disable iff (RST)
        rsvd_wr |=> (mode_q.source == $past(mode_q.source)) && rsvd_hit_q;
    endproperty
    a_rsvd_keep: assert property (p_rsvd_keep) else $error("reserved code used");

    property p_div1_pass;
        @(posedge CLK) disable iff (RST)
        (src_tick_q && mode_q.divide == SCS_DIV_1 && !restart_q && !wr_mode) |=> CORE_TIMEBASE;
    endproperty
    a_div1_pass: assert property (p_div1_pass) else $error("through mode lost tick");

    property p_core_cause;
        @(posedge CLK) disable iff (RST)
        CORE_TIMEBASE |-> $past(src_tick_q);
    endproperty
    a_core_cause: assert property (p_core_cause) else $error("core tick without source");

    property p_step_three;
        @(posedge CLK) disable iff (RST)
        CPU_STEP_CLOCK |-> (core_seen_q == 3'h3);
    endproperty
    a_step_three: assert property (p_step_three) else $error("step not after three ticks");

    property p_mcycle;
        @(posedge CLK) disable iff (RST)
        CPU_STEP_CLOCK |=> (mcyc_q == $past(mcyc_q) + 4'h1);
    endproperty
    a_mcycle: assert property (p_mcycle) else $error("machine cycle not counted");

    property p_ring_runs;
        @(posedge CLK) disable iff (RST)
        ring_tick_q |=> !ring_tick_q;
    endproperty
    a_ring_runs: assert property (p_ring_runs) else $error("on-chip tick too long");

    property p_mode_read;
        @(posedge CLK) disable iff (RST)
        (RD && ADDR == `SCS_ADDR_MODE) |=> (RDATA == $past(mode_q));
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read back wrong");

    property p_step_phase;
        @(posedge CLK) disable iff (RST)
        CPU_STEP_CLOCK |-> (CPU_STEP_PHASE == 2'h0);
    endproperty
    a_step_phase: assert property (p_step_phase) else $error("step phase not restarted");

    property p_phase_range;
        @(posedge CLK) disable iff (RST)
        CPU_STEP_PHASE != 2'h3;
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("step phase out of range");

    property p_rsvd_clear;
        @(posedge CLK) disable iff (RST)
        (wr_stat && WDATA[`SCS_STAT_RSVD_BIT]) |=> !rsvd_hit_q;
    endproperty
    a_rsvd_clear: assert property (p_rsvd_clear) else $error("reserved flag not cleared");

    c_div8: cover property (@(posedge CLK) disable iff (RST) CORE_TIMEBASE && mode_q.divide == SCS_DIV_8);
    c_main: cover property (@(posedge CLK) disable iff (RST) CPU_STEP_CLOCK && mode_q.source == SCS_SRC_MAIN);
    c_sub: cover property (@(posedge CLK) disable iff (RST) CPU_STEP_CLOCK && mode_q.source == SCS_SRC_SUB);
    c_rsvd: cover property (@(posedge CLK) disable iff (RST) rsvd_wr);
endmodule

// ### verif/scs_tb.sv
// Purpose: self-checking bench of the system clock select block
// Assumes: on-chip tick every RDIV cycles, pin sources are periodic
// Notes: main and sub pins get distinct periods so a wrong source pick shows
`timescale 1ns/1ps
module tb;
    import scs_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int RDIV = 2;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic MAIN_OSC_IN = 1'b0;
    logic SUB_OSC_IN = 1'b0;
    logic [1:0] ADDR = 2'h0;
    logic [3:0] WDATA = 4'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [3:0] RDATA;
    scs_mode_t MODE;
    logic CORE_TIMEBASE;
    logic CPU_STEP_CLOCK;
    logic [1:0] CPU_STEP_PHASE;
    logic MACHINE_CYCLE;
    int fails = 0;
    int n_compared = 0;
    int seed = 79318;
    int steps = 0;
    int pcnt = 0;
    int c, s, n, per;
    logic [3:0] m;
    logic [3:0] d;
    logic [3:0] expq[$];
    logic rd_pend = 1'b0;

    always #4 CLK = ~CLK;

    scs_clock_select #(.RING_DIV(RDIV)) i_dut (
        .CLK(CLK), .RST(RST), .MAIN_OSC_IN(MAIN_OSC_IN), .SUB_OSC_IN(SUB_OSC_IN),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MODE(MODE),
        .CORE_TIMEBASE(CORE_TIMEBASE), .CPU_STEP_CLOCK(CPU_STEP_CLOCK),
        .CPU_STEP_PHASE(CPU_STEP_PHASE), .MACHINE_CYCLE(MACHINE_CYCLE)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("Errors: %0d Compared: %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ichk(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("Error at %0t: interval %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [3:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [3:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        expq.push_back(e);
        @(posedge CLK);
        RD <= 1'b0;
    endtask

    // cycles until the next core or step pulse; bounded so a dead divider shows
    task automatic gap(input bit stp, output int k);
        k = 0;
        do begin
            @(negedge CLK);
            k++;
        end while (!((stp ? CPU_STEP_CLOCK : CORE_TIMEBASE) === 1'b1) && k < 600);
        if (k >= 600) begin
            fails++;
            $display("Error at %0t: pulse missing", $time);
        end
    endtask

    // ----------------------------------------
    // pin sources and output watcher
    // ----------------------------------------
    always @(posedge CLK) begin
        pcnt <= pcnt + 1;
        MAIN_OSC_IN <= (pcnt % 4) < 2;
        SUB_OSC_IN <= (pcnt % 6) < 3;
        rd_pend <= RD & ~RST;
        if (RST) begin
            steps <= 0;
        end else if (MACHINE_CYCLE === 1'b1) begin
            steps <= steps + 1;
        end
    end

    always @(negedge CLK) begin
        if (!RST) begin
            if (rd_pend) begin
                chk(RDATA, expq.pop_front());
            end else begin
                chk(RDATA, 4'h0);
            end
            chk({3'h0, MACHINE_CYCLE}, {3'h0, CPU_STEP_CLOCK});
            if (CPU_STEP_CLOCK === 1'b1) begin
                chk({2'h0, CPU_STEP_PHASE}, 4'h0);
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        chk(MODE, 4'hC);
        rd(2'h0, 4'hC);
        rd(2'h1, 4'h0);
        rd(2'h3, 4'h0);
        for (int sr = 0; sr < 3; sr++) begin
            for (int dv = 0; dv < 4; dv++) begin
                m = {dv[1:0], sr[1:0]};
                wr(2'h0, m);
                @(negedge CLK);
                chk(MODE, m);
                rd(2'h1, {2'h0, sr[1:0]});
                gap(1'b1, n);
                gap(1'b0, n);
                gap(1'b0, c);
                per = (sr == 0) ? RDIV : ((sr == 1) ? 4 : 6);
                ichk(c, per << dv);
                gap(1'b1, n);
                gap(1'b1, s);
                ichk(s, 3 * c);
                repeat (2) @(negedge CLK);
                rd(2'h2, steps[3:0]);
            end
        end
        // reserved source code keeps the source, still takes the ratio
        d = 4'($random(seed));
        wr(2'h0, {d[1:0], 2'h3});
        @(negedge CLK);
        chk(MODE, {d[1:0], 2'h2});
        rd(2'h1, 4'h6);
        wr(2'h1, 4'h4);
        rd(2'h1, 4'h2);
        rd(2'h3, 4'h0);
        // unmapped write must leave the mode alone
        wr(2'h3, 4'h1);
        @(negedge CLK);
        chk(MODE, {d[1:0], 2'h2});
        // second reset in mid-run
        @(posedge CLK);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        chk(MODE, 4'hC);
        gap(1'b1, n);
        gap(1'b0, n);
        gap(1'b0, c);
        ichk(c, RDIV * 8);
        tally_and_finish;
    end

    // watchdog, far beyond the expected run of some two thousand cycles
    initial begin
        #(40000 * 8);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish;
    end
endmodule
